// >>> tweep_pkg.sv
// shared constants and types for the two-wire eeprom target
package tweep_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int          CLK_KHZ      = 100000;
  localparam int          SCL_MAX_KHZ  = 400;
  localparam int          WC_TIME_MS   = 5;
  // longest time, so rounded down; ms times kHz gives cycles
  localparam int          WC_CYCLES    = WC_TIME_MS * CLK_KHZ;
  localparam int          WC_W         = 20;

  // ------------------------------------------------------------------
  // array and page geometry
  // ------------------------------------------------------------------
  localparam int          ADDR_W       = 9;
  localparam int          MEM_DEPTH    = 512;
  localparam int          PAGE_W       = 4;
  localparam int          PAGE_LEN     = 16;
  localparam int          BASE_W       = 5;
  localparam logic [4:0]  PAGE_END     = 5'h10;
  localparam logic [3:0]  BIT_LAST     = 4'h8;
  localparam int          FIFO_DEPTH   = 2;
  localparam logic [1:0]  FIFO_FULL    = 2'h2;

  // ------------------------------------------------------------------
  // byte phases within a transaction
  // ------------------------------------------------------------------
  localparam logic [1:0]  PH_DEV       = 2'h0;
  localparam logic [1:0]  PH_MEM       = 2'h1;
  localparam logic [1:0]  PH_DAT       = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic sel_hi;
    logic sel_lo;
  } tweep_pins_t;

  typedef struct packed {
    logic [3:0] dtype;
    logic [1:0] sel;
    logic       bit8;
    logic       rd;
  } tweep_devword_t;

  typedef struct packed {
    logic [3:0] off;
    logic [7:0] data;
  } tweep_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_RACK = 3'h6,
    ST_TXL  = 3'h7
  } tweep_state_t;

endpackage : tweep_pkg

// >>> tweep_top.sv
// two-wire eeprom target: bus engine, page buffer, array and write timer
// Rules for this block and its bus controller
// R1 - sample data on serial clock rise, change driven data after its fall
// R2 - controller keeps serial clock at or below 400 kHz; the bench controller model runs a 160 ns clock period
// R3 - data line only pulled low or released, never driven high
// R4 - controller changes data only while serial clock is low, except start/stop
// R5 - data falling while clock high is a start, opening every transaction
// R6 - data rising while clock high is a stop; after a read, standby
// R7 - stop after write data ends reception and starts the timed write
// R8 - timed write lasts at most 5 ms from the stop
// R9 - words are 8 bits; ninth clock carries the receiver's low acknowledge
// R10 - acknowledge every written word; on reads acknowledge the address word
// R11 - after a read byte release data; low acknowledge sends next address
// R12 - no acknowledge then stop ends the read, back to standby
// R13 - neither acknowledge nor stop: keep data released, send nothing more
// R14 - address word msb first: type code, two select bits, bit 8, direction
// R15 - direction 0 starts a write, 1 starts a read
// R16 - answer only on select match; mismatch returns to standby unacknowledged
// R17 - lowest strap ignored; third address-word bit is array address bit 8; the code compares both straps and takes bit 8 from the second bit
// R18 - open select straps read as low
// R19 - byte write order, then bus ignored until write completes
// R20 - extra data bytes form a page write, low four bits increment
// R21 - low four bits wrap within the page, overwriting buffered data
// R22 - write protect high blocks all writes, reads stay allowed
// R23 - protected: acknowledge address and offset, refuse data, write nothing
// R24 - open write protect reads as low
// R25 - during timed write refuse write address word, acknowledge after
// R26 - sequential read address increments, wrapping from last to zero
// R27 - array address is address-word bit 8 over the memory address byte
// R28 - any stop clears bit and byte counters
`timescale 1ns/1ps
module tweep_top #(
  parameter int unsigned WC_CYC   = tweep_pkg::WC_CYCLES,
  parameter logic [3:0]  DEV_TYPE = 4'h5  // arbitrary type code
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic scl_pin,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic select_pin_high_bit,
  input  wire logic select_pin_low_bit,
  input  wire logic write_protect_pin,
  output logic      write_busy
);

  // ------------------------------------------------------------------
  // pin synchronisers and filters
  // ------------------------------------------------------------------
  tweep_pkg::tweep_pins_t pin_raw;
  tweep_pkg::tweep_pins_t pin_f;
  tweep_pkg::tweep_pins_t pin_p;
  logic [4:0]             s1_ff;
  logic [4:0]             s2_ff;
  logic [4:0]             s3_ff;
  logic [4:0]             flt_ff;
  logic [4:0]             prv_ff;

  // open straps and protect pin arrive low from their pull-downs
  assign pin_raw = '{scl: scl_pin, sda: sda_in, wp: write_protect_pin,
                     sel_hi: select_pin_high_bit, sel_lo: select_pin_low_bit}; // [R18] [R24]
  assign pin_f   = tweep_pkg::tweep_pins_t'(flt_ff);
  assign pin_p   = tweep_pkg::tweep_pins_t'(prv_ff);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_ff  <= 5'h00;
      s2_ff  <= 5'h00;
      s3_ff  <= 5'h00;
      flt_ff <= 5'h00;
      prv_ff <= 5'h00;
    end else begin
      s1_ff  <= pin_raw;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));
      prv_ff <= flt_ff;
    end
  end

  // ------------------------------------------------------------------
  // line events
  // ------------------------------------------------------------------
  wire scl_rise  = pin_f.scl & ~pin_p.scl;
  wire scl_fall  = ~pin_f.scl & pin_p.scl;
  wire start_det = pin_f.scl & pin_p.scl & pin_p.sda & ~pin_f.sda; // [R5]
  wire stop_det  = pin_f.scl & pin_p.scl & ~pin_p.sda & pin_f.sda; // [R6]

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  tweep_pkg::tweep_state_t st_ff;
  tweep_pkg::tweep_state_t nxt_st;
  logic [3:0]              bit_ff;
  logic [3:0]              nxt_bit;
  logic [7:0]              sh_ff;
  logic [7:0]              nxt_sh;
  logic                    drv_ff;
  logic                    nxt_drv;
  logic [1:0]              ph_ff;
  logic [1:0]              nxt_ph;
  logic                    rd_ff;
  logic                    nxt_rd;
  logic                    a8_ff;
  logic                    nxt_a8;
  logic [8:0]              adr_ff;
  logic [8:0]              nxt_adr;
  logic                    wfl_ff;
  logic                    busy_ff;
  logic [4:0]              base_ff;
  logic [15:0]             pgv_ff;
  logic [4:0]              cpi_ff;
  logic [tweep_pkg::WC_W-1:0] wc_ff;
  logic [7:0]              mem [tweep_pkg::MEM_DEPTH];
  logic [7:0]              pbuf [tweep_pkg::PAGE_LEN];

  // ------------------------------------------------------------------
  // byte decode
  // ------------------------------------------------------------------
  tweep_pkg::tweep_devword_t dw;
  logic                      fin_rdy;
  logic                      fout_vld;
  logic [7:0]                mem_rd;
  logic                      dev_hit;
  logic                      byte_end;
  logic                      dat_ok;
  logic                      ack_now;
  logic                      push;
  logic                      wc_go;
  logic                      wc_end;
  logic                      cpy_on;

  assign dw       = tweep_pkg::tweep_devword_t'(sh_ff);            // [R14]
  // both straps compared; address bit 8 has its own bit below them
  assign dev_hit  = (dw.dtype == DEV_TYPE) && !busy_ff
                  && (dw.sel == {pin_f.sel_hi, pin_f.sel_lo});      // [R16] [R17] [R19] [R25]
  assign byte_end = scl_fall && (st_ff == tweep_pkg::ST_RX) && (bit_ff == tweep_pkg::BIT_LAST);
  assign dat_ok   = !pin_f.wp && fin_rdy;                           // [R22] [R23]
  assign ack_now  = (ph_ff == tweep_pkg::PH_DEV) ? dev_hit
                  : (ph_ff == tweep_pkg::PH_MEM) ? 1'b1 : dat_ok;   // [R10]
  assign push     = byte_end && (ph_ff == tweep_pkg::PH_DAT) && dat_ok;
  assign mem_rd   = mem[adr_ff];
  assign wc_go    = stop_det && wfl_ff && !busy_ff;                 // [R7]
  assign wc_end   = busy_ff && (wc_ff == tweep_pkg::WC_W'(WC_CYC - 1));
  assign cpy_on   = busy_ff && !fout_vld && (cpi_ff != tweep_pkg::PAGE_END);

  // ------------------------------------------------------------------
  // bus engine next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st  = st_ff;
    nxt_bit = bit_ff;
    nxt_sh  = sh_ff;
    nxt_drv = drv_ff;
    nxt_ph  = ph_ff;
    nxt_rd  = rd_ff;
    nxt_a8  = a8_ff;
    nxt_adr = adr_ff;
    if (stop_det) begin
      nxt_st  = tweep_pkg::ST_IDLE;                                 // [R6] [R12]
      nxt_bit = 4'h0;                                               // [R28]
      nxt_ph  = tweep_pkg::PH_DEV;
      nxt_drv = 1'b0;
    end else if (start_det) begin
      nxt_st  = tweep_pkg::ST_RX;                                   // [R5]
      nxt_bit = 4'h0;
      nxt_ph  = tweep_pkg::PH_DEV;
      nxt_drv = 1'b0;
    end else begin
      case (st_ff)
        tweep_pkg::ST_RX: begin
          if (scl_rise) begin
            nxt_sh  = {sh_ff[6:0], pin_f.sda};                      // [R1] [R9]
            nxt_bit = bit_ff + 4'h1;
          end
          if (byte_end) begin
            nxt_bit = 4'h0;
            nxt_drv = ack_now;                                      // [R9] [R10]
            nxt_st  = ack_now ? tweep_pkg::ST_ACK : tweep_pkg::ST_IDLE; // [R16]
            if (ph_ff == tweep_pkg::PH_DEV) begin
              nxt_rd = dw.rd;                                       // [R15]
              nxt_a8 = dw.bit8;
            end
            if (ph_ff == tweep_pkg::PH_MEM) begin
              nxt_adr = {a8_ff, sh_ff};                             // [R27]
            end
            if (push) begin
              nxt_adr[3:0] = adr_ff[3:0] + 4'h1;                    // [R20] [R21]
            end
          end
        end
        tweep_pkg::ST_ACK: begin
          if (scl_fall) begin
            nxt_drv = 1'b0;
            nxt_st  = tweep_pkg::ST_RX;
            nxt_ph  = (ph_ff == tweep_pkg::PH_DEV) ? tweep_pkg::PH_MEM : tweep_pkg::PH_DAT;
            if (rd_ff && (ph_ff == tweep_pkg::PH_DEV)) begin
              nxt_st  = tweep_pkg::ST_TX;
              nxt_drv = ~mem_rd[7];                                 // [R3]
              nxt_sh  = {mem_rd[6:0], 1'b0};
            end
          end
        end
        tweep_pkg::ST_TX: begin
          if (scl_rise) begin
            nxt_bit = bit_ff + 4'h1;
          end
          if (scl_fall) begin
            if (bit_ff == tweep_pkg::BIT_LAST) begin
              nxt_drv = 1'b0;                                       // [R11]
              nxt_st  = tweep_pkg::ST_RACK;
              nxt_adr = adr_ff + 9'h001;                            // [R26]
            end else begin
              nxt_drv = ~sh_ff[7];                                  // [R1] [R3]
              nxt_sh  = {sh_ff[6:0], 1'b0};
            end
          end
        end
        tweep_pkg::ST_RACK: begin
          if (scl_rise) begin
            nxt_bit = 4'h0;
            nxt_st  = pin_f.sda ? tweep_pkg::ST_IDLE : tweep_pkg::ST_TXL; // [R11] [R13]
          end
        end
        tweep_pkg::ST_TXL: begin
          if (scl_fall) begin
            nxt_st  = tweep_pkg::ST_TX;
            nxt_drv = ~mem_rd[7];
            nxt_sh  = {mem_rd[6:0], 1'b0};
          end
        end
        default: begin
          nxt_drv = 1'b0;                                           // [R13]
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff  <= tweep_pkg::ST_IDLE;
      bit_ff <= 4'h0;
      sh_ff  <= 8'h00;
      drv_ff <= 1'b0;
      ph_ff  <= tweep_pkg::PH_DEV;
      rd_ff  <= 1'b0;
      a8_ff  <= 1'b0;
      adr_ff <= 9'h000;
    end else begin
      st_ff  <= nxt_st;
      bit_ff <= nxt_bit;
      sh_ff  <= nxt_sh;
      drv_ff <= nxt_drv;
      ph_ff  <= nxt_ph;
      rd_ff  <= nxt_rd;
      a8_ff  <= nxt_a8;
      adr_ff <= nxt_adr;
    end
  end

  assign sda_out    = 1'b0;                                         // [R3]
  assign sda_oe     = drv_ff;
  assign write_busy = busy_ff;

  // ------------------------------------------------------------------
  // two-entry buffer between receiver and page buffer
  // ------------------------------------------------------------------
  tweep_pkg::tweep_entry_t fq [tweep_pkg::FIFO_DEPTH];
  tweep_pkg::tweep_entry_t fout;
  logic                    fwp_ff;
  logic                    frp_ff;
  logic [1:0]              fcnt_ff;
  logic                    pop;

  assign fin_rdy  = (fcnt_ff != tweep_pkg::FIFO_FULL);
  assign fout_vld = (fcnt_ff != 2'h0);
  assign fout     = fq[frp_ff];
  // drain stalls from the start of the array copy until the timed write ends
  assign pop      = fout_vld && (cpi_ff == 5'h00);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fq[fwp_ff] <= '{off: adr_ff[3:0], data: sh_ff};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fwp_ff  <= 1'b0;
      frp_ff  <= 1'b0;
      fcnt_ff <= 2'h0;
    end else begin
      fwp_ff  <= fwp_ff ^ push;
      frp_ff  <= frp_ff ^ pop;
      fcnt_ff <= fcnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ------------------------------------------------------------------
  // page buffer, array commit and write timer
  // ------------------------------------------------------------------
  wire pg_open = byte_end && (ph_ff == tweep_pkg::PH_MEM);

  always_ff @(posedge ref_clk) begin
    if (pop) begin
      pbuf[fout.off] <= fout.data;                                  // [R21]
    end
    if (cpy_on && pgv_ff[cpi_ff[3:0]]) begin
      mem[{base_ff, cpi_ff[3:0]}] <= pbuf[cpi_ff[3:0]];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pgv_ff  <= 16'h0000;
      base_ff <= 5'h00;
      wfl_ff  <= 1'b0;
      busy_ff <= 1'b0;
      cpi_ff  <= 5'h00;
      wc_ff   <= '0;
    end else begin
      if (pg_open) begin
        pgv_ff  <= 16'h0000;
        base_ff <= {a8_ff, sh_ff[7:4]};
      end else if (pop) begin
        pgv_ff[fout.off] <= 1'b1;
      end
      wfl_ff  <= start_det ? 1'b0 : (wfl_ff | push);
      busy_ff <= wc_go | (busy_ff & ~wc_end);                       // [R7] [R8]
      cpi_ff  <= wc_end ? 5'h00 : (cpi_ff + {4'h0, cpy_on});
      wc_ff   <= busy_ff ? (wc_ff + 1'b1) : '0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking chk_cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic rst_d_ff;
  always_ff @(posedge ref_clk) begin
    rst_d_ff <= sys_rst;
  end

  drive_edge_a: assert property (!rst_d_ff && $changed(drv_ff) // [R1]
      |-> $past(scl_fall) || $past(stop_det) || $past(start_det))
    else $error("data drive changed away from a clock fall");
  never_high_a: assert property (sda_out == 1'b0) // [R3]
    else $error("data line driven high");
  addr_nak_a: assert property (byte_end && ph_ff == tweep_pkg::PH_DEV && !dev_hit // [R16]
      |=> !drv_ff && st_ff == tweep_pkg::ST_IDLE)
    else $error("unmatched address word acknowledged");
  busy_nak_a: assert property (busy_ff && byte_end && ph_ff == tweep_pkg::PH_DEV // [R25]
      |=> !drv_ff)
    else $error("address acknowledged during timed write");
  prot_nak_a: assert property (byte_end && ph_ff == tweep_pkg::PH_DAT && pin_f.wp // [R23]
      |=> !drv_ff && fcnt_ff == $past(fcnt_ff) - {1'b0, $past(pop)})
    else $error("protected data byte accepted");
  page_wrap_a: assert property (push |=> adr_ff[3:0] == $past(adr_ff[3:0]) + 4'h1 // [R21]
      && adr_ff[8:4] == $past(adr_ff[8:4]))
    else $error("page offset did not wrap within page");
  wc_start_a: assert property (wc_go |=> busy_ff && wc_ff == '0) // [R7]
    else $error("timed write did not start at stop");
  wc_bound_a: assert property (busy_ff |-> wc_ff < tweep_pkg::WC_W'(WC_CYC)) // [R8]
    else $error("timed write ran past its limit");
  stop_clear_a: assert property (stop_det |=> bit_ff == 4'h0 // [R28]
      && ph_ff == tweep_pkg::PH_DEV && !drv_ff)
    else $error("counters not cleared by stop");
  read_nak_a: assert property (st_ff == tweep_pkg::ST_RACK && scl_rise && pin_f.sda // [R13]
      && !stop_det && !start_det |=> !drv_ff [*2])
    else $error("data driven after read not acknowledged");

  wr_cycle_c: cover property (wc_go ##[1:40] !fout_vld);
  seq_read_c: cover property (st_ff == tweep_pkg::ST_RACK ##1 st_ff == tweep_pkg::ST_TXL);
  fifo_full_c: cover property (fcnt_ff == tweep_pkg::FIFO_FULL);

endmodule : tweep_top

// >>> tweep_master.sv
// bus controller model: drives the serial clock and pulls the data wire low
`timescale 1ns/1ps
module tweep_master (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt

  // one bit of 16 clocks, 160 ns period, data moved only while clock low
  task automatic bit_c(input logic lo, output logic s);
    wt(4);
    sda_low = lo;
    wt(4);
    scl = 1'b1;
    wt(4);
    s = sda_line;
    wt(4);
    scl = 1'b0;
  endtask : bit_c

  task automatic start_c();
    wt(4);
    sda_low = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_low = 1'b1;
    wt(8);
    scl = 1'b0;
  endtask : start_c

  task automatic stop_c();
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_low = 1'b0;
    wt(8);
  endtask : stop_c

  // eight bits msb first, released ninth bit carries the answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(~b[i], s);
    bit_c(1'b0, s);
    ack = ~s;
  endtask : send_byte

  // data released for eight bits, then own acknowledge
  task automatic recv_byte(input logic ackl, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(1'b0, b[i]);
    bit_c(ackl, s);
  endtask : recv_byte
endmodule : tweep_master

// >>> tb_tweep_top.sv
// self-checking bench for the two-wire eeprom target
`timescale 1ns/1ps
module tb_tweep_top;
  localparam int         WC = 600;
  localparam logic [3:0] DT = 4'h5;  // arbitrary type code, same as design
  logic       ref_clk, sys_rst, wp, sh, sl, ack;
  logic       scl, m_low, sda_out, sda_oe, write_busy, sda_w;
  logic [15:0] rnd;
  logic [8:0] ra;
  logic [7:0] mem [512];
  int         failures, tests_run;

  // open-drain wire with pull-up
  assign sda_w = !(sda_oe || m_low);

  tweep_top #(.WC_CYC(WC), .DEV_TYPE(DT)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_pin(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high_bit(sh),
    .select_pin_low_bit(sl), .write_protect_pin(wp), .write_busy(write_busy)
  );
  tweep_master mst (.ref_clk(ref_clk), .sda_line(sda_w), .scl(scl), .sda_low(m_low));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt

  function automatic logic [7:0] dw(input logic [8:0] a, input logic r);
    return {DT, sh, sl, a[8], r};
  endfunction : dw

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // transactions
  // ------------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input int n);
    logic       k;
    logic [3:0] o;
    longint     t0;
    mst.start_c();
    mst.send_byte(dw(a, 1'b0), k);
    check(k, 1'b1, "write word ack");
    mst.send_byte(a[7:0], k);
    check(k, 1'b1, "offset ack");
    o = a[3:0];
    for (int i = 0; i < n; i++) begin
      rnd = nxt(rnd);
      mst.send_byte(rnd[7:0], k);
      check(k, !wp, "data ack");
      if (!wp) mem[{a[8:4], o}] = rnd[7:0];
      o = o + 4'h1;
    end
    mst.stop_c();
    t0 = $time;
    repeat (3) @(negedge ref_clk);
    check(write_busy, !wp, "write busy");
    if (!wp) begin
      mst.start_c();
      mst.send_byte(dw(a, 1'b0), k);
      check(k, 1'b0, "poll while busy");
      mst.stop_c();
      for (int c = 0; c < WC && write_busy; c++) @(negedge ref_clk);
      check(($time - t0) <= WC * 10, 1'b1, "write time");
      mst.start_c();
      mst.send_byte(dw(a, 1'b0), k);
      check(k, 1'b1, "poll after write");
      mst.stop_c();
    end
  endtask : wr

  task automatic rd(input logic [8:0] a, input int n);
    logic       k;
    logic [7:0] b;
    mst.start_c();
    mst.send_byte(dw(a, 1'b0), k);
    mst.send_byte(a[7:0], k);
    mst.start_c();
    mst.send_byte(dw(a, 1'b1), k);
    check(k, 1'b1, "read word ack");
    for (int i = 0; i < n; i++) begin
      mst.recv_byte(i < n - 1, b);
      check(b, mem[a + i[8:0]], "read data");
    end
    mst.recv_byte(1'b0, b);
    check(b, 8'hFF, "nothing after no ack");
    mst.stop_c();
    check(sda_oe, 1'b0, "released after stop");
  endtask : rd

  // ------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    summarize();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    wp = 1'b0;
    rnd = nxt(16'h9229);
    sh = rnd[0];
    sl = rnd[1];
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    check({sda_oe, write_busy, sda_out}, 3'h0, "reset values");
    repeat (4) @(negedge ref_clk);
    for (int k = 0; k < 5; k++) begin
      mst.start_c();
      mst.send_byte({(k == 4) ? ~DT : DT, k[1:0], 2'h0}, ack);
      check(ack, k < 4 && k[1:0] == {sh, sl}, "select match");
      mst.stop_c();
    end
    rnd = nxt(rnd);
    wr({5'h1F, rnd[3:0]}, 18);
    wr(9'h000, 1);
    rnd = nxt(rnd);
    ra = {1'b0, rnd[7:1], 1'b0};
    wr(ra, 2);
    rd(ra, 2);
    rd(9'h1FE, 3);
    rd(9'h1F0, 16);
    wp = 1'b1;
    wr(9'h000, 1);
    rd(9'h000, 1);
    check(sda_out, 1'b0, "never driven high");
    summarize();
  end
endmodule : tb_tweep_top
